/* File: common/cffr_defines.svh */
// register offsets, field positions and reset values of the fault/flag bank
`ifndef CFFR_DEFINES_SVH
`define CFFR_DEFINES_SVH

`define CFFR_FAULT_OFFSET       8'h21
`define CFFR_FLAG_OFFSET        8'h22
`define CFFR_REG_RESET          8'h00
`define CFFR_READ_IDLE          8'h00

`define CFFR_FAULT_SYS_SHORT    7
`define CFFR_FAULT_SYS_OVP      6
`define CFFR_FAULT_BOOST_OVP    5
`define CFFR_FAULT_BOOST_UVP    4
`define CFFR_FAULT_THERMAL      2

`define CFFR_FLAG_ICURR         7
`define CFFR_FLAG_VLIM          6
`define CFFR_FLAG_WDOG          5
`define CFFR_FLAG_WEAK          4
`define CFFR_FLAG_PGOOD         3
`define CFFR_FLAG_IN2           2
`define CFFR_FLAG_IN1           1
`define CFFR_FLAG_BUS           0

`endif

/* File: common/cffr_pkg.sv */
// types shared by the fault/flag register bank
package cffr_pkg;
  typedef logic [7:0] cffr_byte_t;
  // per-flag detection style
  typedef enum logic [1:0] {
    CFFR_DET_RISE = 2'b01,
    CFFR_DET_ANY  = 2'b10
  } cffr_det_e;
endpackage

/* File: common/cffr_evt_if.sv */
// carrier between event detectors and the flag register
interface cffr_evt_if;
  logic [7:0] level;
  logic [7:0] hit;
  modport det (input level, output hit);
  modport reg_side (output level, input hit);
endinterface

/* File: core/cffr_edge_det.sv */
// per-bit edge detectors feeding the flag register
`include "cffr_defines.svh"
module cffr_edge_det
  import cffr_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst_b,
  cffr_evt_if.det    evt
);
  // bits 3..0 flag any change, the rest only rising edges
  localparam logic [7:0] ANY_MASK = 8'h0F;

  logic [7:0] prev_r;

  // ****************************************
  // previous level, zero at reset
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      prev_r <= `CFFR_REG_RESET;
    end else begin
      prev_r <= evt.level;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_det
      if (ANY_MASK[g]) begin : g_any
        assign evt.hit[g] = evt.level[g] ^ prev_r[g];
      end else begin : g_rise
        assign evt.hit[g] = evt.level[g] & ~prev_r[g];
      end
    end
  endgenerate
endmodule

/* File: core/cffr_regs.sv */
// charger fault status and event flag registers, read-only to the host
`include "cffr_defines.svh"
module cffr_regs
  import cffr_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_sys_rail_short_fault,
  input  wire logic       i_sys_rail_overvolt_fault,
  input  wire logic       i_boost_out_overvolt_fault,
  input  wire logic       i_boost_out_undervolt_fault,
  input  wire logic       i_die_thermal_shutdown_fault,
  input  wire logic       i_input_current_regulation,
  input  wire logic       i_boost_current_regulation,
  input  wire logic       i_input_voltage_regulation,
  input  wire logic       i_boost_voltage_regulation,
  input  wire logic       i_bus_watchdog_expiry,
  input  wire logic       i_weak_source,
  input  wire logic       i_power_good_state,
  input  wire logic       i_second_input_present,
  input  wire logic       i_first_input_present,
  input  wire logic       i_bus_input_present,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_rd_addr,
  output logic      [7:0] o_rd_data,
  output logic      [7:0] o_fault_status_one,
  output logic      [7:0] o_charger_event_flags_zero
);
  cffr_byte_t fault_r;
  cffr_byte_t fault_nxt;
  cffr_byte_t flags_r;
  cffr_byte_t flags_nxt;
  cffr_byte_t rd_data_r;
  logic       flag_rd;

  cffr_evt_if evt ();

  // ****************************************
  // event sources
  // ****************************************
  // regulation loops share one flag between charge and boost modes
  always_comb begin
    evt.level = 8'h00;
    evt.level[`CFFR_FLAG_ICURR] = i_input_current_regulation |
                                  i_boost_current_regulation;
    evt.level[`CFFR_FLAG_VLIM]  = i_input_voltage_regulation |
                                  i_boost_voltage_regulation;
    evt.level[`CFFR_FLAG_WDOG]  = i_bus_watchdog_expiry;
    evt.level[`CFFR_FLAG_WEAK]  = i_weak_source;
    evt.level[`CFFR_FLAG_PGOOD] = i_power_good_state;
    evt.level[`CFFR_FLAG_IN2]   = i_second_input_present;
    evt.level[`CFFR_FLAG_IN1]   = i_first_input_present;
    evt.level[`CFFR_FLAG_BUS]   = i_bus_input_present;
  end

  cffr_edge_det u_edge_det (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .evt       (evt.det)
  );

  // ****************************************
  // fault status: live image of detectors
  // ****************************************
  always_comb begin
    fault_nxt = 8'h00; // reserved bits stay zero
    fault_nxt[`CFFR_FAULT_SYS_SHORT]  = i_sys_rail_short_fault;
    fault_nxt[`CFFR_FAULT_SYS_OVP]    = i_sys_rail_overvolt_fault;
    fault_nxt[`CFFR_FAULT_BOOST_OVP]  = i_boost_out_overvolt_fault;
    fault_nxt[`CFFR_FAULT_BOOST_UVP]  = i_boost_out_undervolt_fault;
    fault_nxt[`CFFR_FAULT_THERMAL]    = i_die_thermal_shutdown_fault;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      fault_r <= `CFFR_REG_RESET;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // ****************************************
  // event flags: sticky, clear on read
  // ****************************************
  assign flag_rd = i_rd_en && (i_rd_addr == `CFFR_FLAG_OFFSET);

  // set wins over the read clear so a coincident event survives
  always_comb begin
    flags_nxt = flag_rd ? evt.hit : (flags_r | evt.hit);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      flags_r <= `CFFR_REG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************
  // read port: no write path exists
  // ****************************************
  // data registered one cycle after the strobe; flag snapshot is pre-clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rd_data_r <= `CFFR_REG_RESET;
    end else if (i_rd_en) begin
      case (i_rd_addr)
        `CFFR_FAULT_OFFSET: rd_data_r <= fault_r;
        `CFFR_FLAG_OFFSET:  rd_data_r <= flags_r;
        default:            rd_data_r <= `CFFR_READ_IDLE;
      endcase
    end
  end

  assign o_rd_data                  = rd_data_r;
  assign o_fault_status_one         = fault_r;
  assign o_charger_event_flags_zero = flags_r;
endmodule

/* File: tb/cffr_host.sv */
// host model reading the register bank
module cffr_host (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_en = 1'b0,
  output logic      [7:0] o_rd_addr = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_rd_en = 1'b1;
    o_rd_addr = a;
    @(negedge i_ref_clk);
    d = i_rd_data;
    o_rd_en = 1'b0;
    o_rd_addr = ~a; // never leave a stale address on the port
  endtask
endmodule

/* File: tb/cffr_regs_properties.sv */
// assertions on the fault and flag register bank
module cffr_regs_properties (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic       i_power_good_state,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_fault_status_one,
  input wire logic [7:0] o_charger_event_flags_zero
);
  wire logic [7:0] fl = o_charger_event_flags_zero;
  wire logic       pg = i_power_good_state;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // strobe on the flag offset
  sequence flag_read_s;
    i_rd_en && i_rd_addr == 8'h22;
  endsequence
  // power-good moved with a valid history behind it
  sequence pg_move_s;
    $past(i_rst_b) && $changed(pg);
  endsequence
  fault_rsv_a: assert property (!(o_fault_status_one & 8'h0B))
    else $error("reserved fault bit set");
  // guarded: edge history restarts from zero at reset
  power_good_change_event_a: assert property (
    pg_move_s |=> fl[3]) else $error("power_good_change_event lost");
  pg_hold_a: assert property (
    fl[3] && !i_rd_en |=> fl[3]) else $error("flag dropped");
  rd_fault_a: assert property (
    i_rd_en && i_rd_addr == 8'h21 |=> o_rd_data == $past(o_fault_status_one))
    else $error("fault read");
  rd_flag_a: assert property (
    flag_read_s |=> o_rd_data == $past(fl)) else $error("flag read");
  rd_clear_a: assert property (
    flag_read_s ##0 ($past(i_rst_b) && !$changed(pg)) |=> !fl[3])
    else $error("no clear");
  rd_unmap_a: assert property (
    i_rd_en && !(i_rd_addr inside {8'h21, 8'h22}) |=> o_rd_data == 8'h00)
    else $error("unmapped read");
  rd_hold_a: assert property (
    !i_rd_en |=> $stable(o_rd_data)) else $error("read data moved");
endmodule
bind cffr_regs cffr_regs_properties u_chk (
  .i_ref_clk                  (i_ref_clk),
  .i_rst_b                    (i_rst_b),
  .i_power_good_state         (i_power_good_state),
  .i_rd_en                    (i_rd_en),
  .i_rd_addr                  (i_rd_addr),
  .o_rd_data                  (o_rd_data),
  .o_fault_status_one         (o_fault_status_one),
  .o_charger_event_flags_zero (o_charger_event_flags_zero)
);

/* File: tb/tb_cffr_regs.sv */
// bench for the fault and flag register bank
module tb_cffr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [14:0] src = '0;
  logic        en;
  logic [7:0]  ad;
  logic [7:0]  dat;
  logic [7:0]  d;
  logic [7:0]  fault_o;
  logic [7:0]  flag_o;
  int          error_cnt = 0;
  int          check_count = 0;
  cffr_regs dut (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_sys_rail_short_fault(src[14]), .i_sys_rail_overvolt_fault(src[13]),
    .i_boost_out_overvolt_fault(src[12]),
    .i_boost_out_undervolt_fault(src[11]),
    .i_die_thermal_shutdown_fault(src[10]),
    .i_input_current_regulation(src[9]),
    .i_boost_current_regulation(src[8]),
    .i_input_voltage_regulation(src[7]),
    .i_boost_voltage_regulation(src[6]), .i_bus_watchdog_expiry(src[5]),
    .i_weak_source(src[4]), .i_power_good_state(src[3]),
    .i_second_input_present(src[2]), .i_first_input_present(src[1]),
    .i_bus_input_present(src[0]), .i_rd_en(en), .i_rd_addr(ad),
    .o_rd_data(dat), .o_fault_status_one(fault_o),
    .o_charger_event_flags_zero(flag_o));
  cffr_host host (.i_ref_clk(clk), .i_rd_data(dat), .o_rd_en(en),
    .o_rd_addr(ad));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic t_reset;
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h5A, 8'h00);
    chk(fault_o, 8'h00);
    chk(flag_o, 8'h00);
  endtask
  task automatic t_fault;
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      b = 8'h04 << i + (i > 0);
      src[10+i] = 1'b1;
      rd(8'h21, b);
      chk(fault_o, b);
      src[10+i] = 1'b0;
    end
  endtask
  task automatic t_flag;
    logic [7:0] b;
    for (int j = 0; j < 10; j++) begin
      b = 8'h01 << (j < 6 ? j : j / 2 + 3);
      src[j] = 1'b1;
      @(negedge clk);
      chk(flag_o, b);
      rd(8'h22, b);
      rd(8'h22, 8'h00);
      src[j] = 1'b0;
      rd(8'h22, j < 4 ? b : 8'h00);
    end
  endtask
  // an event landing in the clearing cycle must survive the read
  task automatic t_race;
    src[4] = 1'b1;
    repeat (5) @(negedge clk);
    chk(flag_o, 8'h10);
    fork
      rd(8'h22, 8'h10);
      begin
        @(negedge clk);
        src[0] = 1'b1;
      end
    join
    chk(flag_o, 8'h01);
    rd(8'h22, 8'h01);
    src[4] = 1'b0;
    src[0] = 1'b0;
    rd(8'h22, 8'h01);
    rd(8'h22, 8'h00);
  endtask
  task automatic t_midreset;
    src[14] = 1'b1;
    src[3] = 1'b1;
    rd(8'h21, 8'h80);
    chk(flag_o, 8'h08);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk(fault_o, 8'h00);
    chk(flag_o, 8'h00);
    chk(dat, 8'h00);
    src[14] = 1'b0;
    src[3] = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_fault;
    t_flag;
    t_race;
    t_midreset;
    stop_test;
  end
endmodule
